/* brse_core.sv */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
// What this block does
// RULE1: Each instruction cycle is four consecutive clock periods.
// RULE2: Instructions take one cycle, or two with a no-operation second cycle on a skip or branch.
// RULE3: The destination bit sends a byte result to the accumulator when 0, to the file when 1.
// RULE4: Ignored opcode bits never affect decoding.
// RULE5: A three-bit field selects the bit of the eight-bit file register.
// RULE6: Bit clear clears the selected bit in one cycle and keeps the flags.
// RULE7: Bit set sets the selected bit in one cycle and keeps the flags.
// RULE8: Bit test skips the next instruction only when the bit is zero, flags untouched.
// RULE9: A taken skip discards the prefetched word and runs a no-operation instead.
// RULE10: Interrupt return pops the stack into the counter, sets the global enable, two cycles.
// RULE11: Literal return loads the accumulator, pops the stack into the counter, two cycles.
// RULE12: Subroutine return pops the stack into the counter in two cycles, flags unchanged.
// RULE13: Literal subtract puts literal minus accumulator in the accumulator and sets C, DC, Z.
// RULE14: File subtract computes file minus accumulator, routed by the destination bit, sets C, DC, Z.
// RULE15: Carry after a subtraction means no borrow, and the result wraps in eight bits.
// RULE16: The file address field is seven bits, 0x00 to 0x7F.
// RULE17: Zero is set on a zero result and digit carry means no borrow from the low nibble.
module brse_core
  import brse_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [13:0] INSTR_WORD,
  input  wire logic [12:0] STACK_TOP_ENTRY,
  input  wire logic [7:0]  FILE_RDATA,
  input  wire logic [7:0]  INTERRUPT_CONTROL_REGISTER,
  output      logic [12:0] PC,
  output      logic        FETCH,
  output      logic        STACK_POP,
  output      logic [6:0]  FILE_ADDR,
  output      logic [7:0]  FILE_WDATA,
  output      logic        FILE_WE,
  output      logic        INTERRUPT_CONTROL_REGISTER_WE,
  output      logic [7:0]  INTERRUPT_CONTROL_REGISTER_WDATA,
  output      logic [7:0]  ACC,
  output      logic        CARRY,
  output      logic        DIGIT_CARRY,
  output      logic        ZERO,
  output      logic        GLOBAL_INTERRUPT_ENABLE,
  output      logic        NOP_CYCLE
);

  typedef struct packed {
    logic [1:0]  q;
    logic        flush;
    logic        hold;
    logic [12:0] pc;
    logic        fetch;
    logic        pop;
    logic [6:0]  faddr;
    logic [7:0]  fwdata;
    logic        fwe;
    logic        iwe;
    logic [7:0]  iwdata;
    logic [7:0]  acc;
    logic        c;
    logic        dc;
    logic        z;
    logic        global_interrupt_enable;
    logic        nop;
  } brse_state_t;

  brse_state_t state_reg;
  brse_state_t state_next;

  brse_op_t   op;
  logic [6:0] faddr;
  logic [2:0] bsel;
  logic [7:0] literal;
  logic       dest_file;
  logic [7:0] sub_a;
  logic [7:0] diff;
  logic       sub_c;
  logic       sub_dc;
  logic       sub_z;

  brse_decode u_decode (
    .instr     (INSTR_WORD),
    .op        (op),
    .faddr     (faddr),
    .bsel      (bsel),
    .literal   (literal),
    .dest_file (dest_file)
  );

  // File subtract uses the file operand, literal subtract the literal.
  assign sub_a = (op == BRSE_OP_SUBF) ? FILE_RDATA : literal;

  brse_sub u_sub (
    .minuend     (sub_a),
    .subtrahend  (state_reg.acc),
    .diff        (diff),
    .carry       (sub_c),
    .digit_carry (sub_dc),
    .zero        (sub_z)
  );

  always_comb begin
    logic [7:0] mask;
    logic       exec;
    mask       = 8'h01 << bsel;                    // [RULE5]
    exec       = (state_reg.q == Q_LAST);          // [RULE1]
    state_next = state_reg;
    state_next.fetch = 1'b0;
    state_next.pop   = 1'b0;
    state_next.fwe   = 1'b0;
    state_next.iwe   = 1'b0;
    state_next.faddr = faddr;                      // [RULE16]
    state_next.q     = state_reg.q + 2'h1;         // [RULE1]
    if (exec) begin
      state_next.fetch = 1'b1;
      // After a return the counter already holds the return address; advancing it
      // here would skip the first instruction there, so it is fetched again. [RULE2]
      state_next.pc    = state_reg.hold ? state_reg.pc : state_reg.pc + 13'h0001;
      state_next.hold  = 1'b0;
      state_next.nop   = state_reg.flush;
      state_next.flush = 1'b0;
      // A flushed word is the prefetched one; it is dropped and nothing runs. [RULE2] [RULE9]
      if (!state_reg.flush) begin
        case (op)
          BRSE_OP_BCLR: begin
            state_next.fwdata = FILE_RDATA & ~mask;  // [RULE6]
            state_next.fwe    = 1'b1;
          end
          BRSE_OP_BSET: begin
            state_next.fwdata = FILE_RDATA | mask;   // [RULE7]
            state_next.fwe    = 1'b1;
          end
          BRSE_OP_BTSC: begin
            state_next.flush = ((FILE_RDATA & mask) == 8'h00); // [RULE8] [RULE9]
          end
          BRSE_OP_RETI: begin
            state_next.pc     = STACK_TOP_ENTRY;     // [RULE10]
            state_next.pop    = 1'b1;
            state_next.flush  = 1'b1;
            state_next.global_interrupt_enable    = 1'b1;
            state_next.hold   = 1'b1;
            state_next.iwe    = 1'b1;
            state_next.iwdata = INTERRUPT_CONTROL_REGISTER | (8'h01 << GIE_BIT); // [RULE10]
          end
          BRSE_OP_RETL: begin
            state_next.acc   = literal;              // [RULE11]
            state_next.hold  = 1'b1;
            state_next.pc    = STACK_TOP_ENTRY;
            state_next.pop   = 1'b1;
            state_next.flush = 1'b1;
          end
          BRSE_OP_RETS: begin
            state_next.pc    = STACK_TOP_ENTRY;      // [RULE12]
            state_next.hold  = 1'b1;
            state_next.pop   = 1'b1;
            state_next.flush = 1'b1;
          end
          BRSE_OP_SUBL: begin
            state_next.acc = diff;                   // [RULE13]
            state_next.c   = sub_c;                  // [RULE15]
            state_next.dc  = sub_dc;                 // [RULE17]
            state_next.z   = sub_z;                  // [RULE17]
          end
          BRSE_OP_SUBF: begin
            if (dest_file) begin                     // [RULE3] [RULE14]
              state_next.fwdata = diff;
              state_next.fwe    = 1'b1;
            end else begin
              state_next.acc = diff;
            end
            state_next.c  = sub_c;                   // [RULE15]
            state_next.dc = sub_dc;                  // [RULE17]
            state_next.z  = sub_z;                   // [RULE17]
          end
          default: begin
          end
        endcase
      end
    end
    // The global enable mirrors the control register outside our own set.
    // It is held one more clock while our write reaches the register, to avoid a dip.
    if (!(exec && state_next.iwe) && !state_reg.iwe) begin
      state_next.global_interrupt_enable = INTERRUPT_CONTROL_REGISTER[GIE_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg <= '{q: Q_RESET, pc: PC_RESET, acc: ACC_RESET, fwdata: 8'h00,
                     iwdata: 8'h00, faddr: 7'h00, default: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign PC                      = state_reg.pc;
  assign FETCH                   = state_reg.fetch;
  assign STACK_POP               = state_reg.pop;
  assign FILE_ADDR               = state_reg.faddr;
  assign FILE_WDATA              = state_reg.fwdata;
  assign FILE_WE                 = state_reg.fwe;
  assign INTERRUPT_CONTROL_REGISTER_WE               = state_reg.iwe;
  assign INTERRUPT_CONTROL_REGISTER_WDATA            = state_reg.iwdata;
  assign ACC                     = state_reg.acc;
  assign CARRY                   = state_reg.c;
  assign DIGIT_CARRY             = state_reg.dc;
  assign ZERO                    = state_reg.z;
  assign GLOBAL_INTERRUPT_ENABLE = state_reg.global_interrupt_enable;
  assign NOP_CYCLE               = state_reg.nop;

endmodule : brse_core

/* brse_pkg.sv */
package brse_pkg;

  localparam int          INSTR_W         = 14;
  localparam int          DATA_W          = 8;
  localparam int          FADDR_W         = 7;
  localparam int          PC_W            = 13;
  localparam int          STACK_DEPTH     = 8;
  localparam int          QPHASES         = 4;
  localparam logic [1:0]  Q_LAST          = 2'h3;
  localparam logic [1:0]  Q_RESET         = 2'h0;
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic [12:0] PC_RESET        = 13'h0000;
  localparam int          GIE_BIT         = 7;
  localparam int          STAT_C_BIT      = 0;
  localparam int          STAT_DC_BIT     = 1;
  localparam int          STAT_Z_BIT      = 2;
  localparam logic [13:0] RET_SUB_CODE    = 14'h0008;
  localparam logic [13:0] RET_INT_CODE    = 14'h0009;
  localparam logic [13:0] NOP_CODE        = 14'h0000;
  localparam logic [3:0]  BIT_CLR_OP      = 4'h4;
  localparam logic [3:0]  BIT_SET_OP      = 4'h5;
  localparam logic [3:0]  BIT_TSC_OP      = 4'h6;
  localparam logic [3:0]  LIT_RET_OP      = 4'hD;
  localparam logic [4:0]  LIT_SUB_OP      = 5'h1E;
  localparam logic [5:0]  FILE_SUB_OP     = 6'h02;

  typedef enum logic [3:0] {
    BRSE_OP_NONE,
    BRSE_OP_BCLR,
    BRSE_OP_BSET,
    BRSE_OP_BTSC,
    BRSE_OP_RETI,
    BRSE_OP_RETL,
    BRSE_OP_RETS,
    BRSE_OP_SUBL,
    BRSE_OP_SUBF
  } brse_op_t;

endpackage : brse_pkg

/* brse_decode.sv */
`timescale 1ns/1ps
module brse_decode
  import brse_pkg::*;
(
  input  wire logic [13:0] instr,
  output      brse_op_t    op,
  output      logic [6:0]  faddr,
  output      logic [2:0]  bsel,
  output      logic [7:0]  literal,
  output      logic        dest_file
);

  function automatic brse_op_t decode_op(input logic [13:0] w);
    brse_op_t o;
    o = BRSE_OP_NONE;
    // Bits marked ignored in a pattern are never compared. [RULE4]
    if (w == RET_SUB_CODE)                o = BRSE_OP_RETS;  // [RULE12]
    else if (w == RET_INT_CODE)           o = BRSE_OP_RETI;  // [RULE10]
    else if (w[13:10] == BIT_CLR_OP)      o = BRSE_OP_BCLR;  // [RULE6]
    else if (w[13:10] == BIT_SET_OP)      o = BRSE_OP_BSET;  // [RULE7]
    else if (w[13:10] == BIT_TSC_OP)      o = BRSE_OP_BTSC;  // [RULE8]
    else if (w[13:10] == LIT_RET_OP)      o = BRSE_OP_RETL;  // [RULE11] [RULE4]
    else if (w[13:9] == LIT_SUB_OP)       o = BRSE_OP_SUBL;  // [RULE13] [RULE4]
    else if (w[13:8] == FILE_SUB_OP)      o = BRSE_OP_SUBF;  // [RULE14]
    return o;
  endfunction : decode_op

  always_comb begin
    op        = decode_op(instr);
    faddr     = instr[6:0];   // [RULE16]
    bsel      = instr[9:7];   // [RULE5]
    literal   = instr[7:0];
    dest_file = instr[7];     // [RULE3]
  end

endmodule : brse_decode

/* brse_sub.sv */
`timescale 1ns/1ps
module brse_sub
  import brse_pkg::*;
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  output      logic [7:0] diff,
  output      logic       carry,
  output      logic       digit_carry,
  output      logic       zero
);

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    // Carry is the inverted borrow, so it is set on a zero or positive result. [RULE15]
    full        = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    low         = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    diff        = full[7:0];
    carry       = full[8];     // [RULE15]
    digit_carry = low[4];      // [RULE17]
    zero        = (full[7:0] == 8'h00); // [RULE17]
  end

endmodule : brse_sub

/* brse_prog_mem.sv */
`timescale 1ns/1ps
module brse_prog_mem
  import brse_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        fetch,
  input  wire logic [12:0] pc,
  output      logic [13:0] word
);
  logic [13:0] mem [0:127];

  // The word changes only after a fetch or during reset, so it stays stable over the whole execute cycle.
  always_ff @(posedge clock) begin
    if (rst || fetch) begin
      word <= mem[pc[6:0]];
    end
  end
endmodule : brse_prog_mem

/* brse_core_sva.sv */
`timescale 1ns/1ps
module brse_core_sva
  import brse_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic [13:0] INSTR_WORD,
  input wire logic [12:0] STACK_TOP_ENTRY,
  input wire logic [7:0]  FILE_RDATA,
  input wire logic [12:0] PC,
  input wire logic        FETCH,
  input wire logic        STACK_POP,
  input wire logic [7:0]  FILE_WDATA,
  input wire logic        FILE_WE,
  input wire logic        INTERRUPT_CONTROL_REGISTER_WE,
  input wire logic [7:0]  INTERRUPT_CONTROL_REGISTER_WDATA,
  input wire logic [7:0]  ACC,
  input wire logic        CARRY,
  input wire logic        DIGIT_CARRY,
  input wire logic        ZERO,
  input wire logic        GLOBAL_INTERRUPT_ENABLE,
  input wire logic        NOP_CYCLE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence exec_done;
    FETCH && !NOP_CYCLE;
  endsequence
  sequence flushed_next;
    ##4 (FETCH && NOP_CYCLE);
  endsequence

  fetch_period_a: assert property (FETCH |=> !FETCH [*3] ##1 FETCH)
    else $error("Fetch pulses are not four clocks apart.");
  pop_flush_a: assert property (STACK_POP |-> flushed_next)
    else $error("A return was not followed by a flushed cycle.");
  pop_pc_a: assert property (STACK_POP |-> PC == $past(STACK_TOP_ENTRY))
    else $error("The counter did not take the stack top.");
  ret_target_a: assert property (STACK_POP |-> ##4 (FETCH && $stable(PC)))
    else $error("The return address was not fetched for the next instruction.");
  ret_pop_a: assert property (exec_done and $past(INSTR_WORD) == RET_SUB_CODE
    or exec_done and $past(INSTR_WORD[13:10]) == LIT_RET_OP |-> STACK_POP)
    else $error("A return did not pop the stack.");
  gie_set_a: assert property (exec_done and $past(INSTR_WORD) == RET_INT_CODE |->
    STACK_POP && INTERRUPT_CONTROL_REGISTER_WE && INTERRUPT_CONTROL_REGISTER_WDATA[GIE_BIT] && GLOBAL_INTERRUPT_ENABLE)
    else $error("Interrupt return did not set the global enable.");
  skip_taken_a: assert property (exec_done and $past(INSTR_WORD[13:10]) == BIT_TSC_OP
    |-> ##4 (NOP_CYCLE == !$past(FILE_RDATA[INSTR_WORD[9:7]], 5)))
    else $error("Skip did not follow the tested bit.");
  bit_write_a: assert property (FILE_WE && $past(INSTR_WORD[13:12]) == 2'h1 |->
    FILE_WDATA == ($past(INSTR_WORD[10]) ? ($past(FILE_RDATA) | (8'h01 << $past(INSTR_WORD[9:7])))
    : ($past(FILE_RDATA) & ~(8'h01 << $past(INSTR_WORD[9:7])))))
    else $error("Bit operation wrote the wrong value.");
  flags_hold_a: assert property (FETCH && $past(INSTR_WORD[13:12]) == 2'h1 |->
    $stable({CARRY, DIGIT_CARRY, ZERO}))
    else $error("A bit operation changed the flags.");
  lit_sub_a: assert property (exec_done and $past(INSTR_WORD[13:9]) == LIT_SUB_OP |->
    ACC == 8'($past(INSTR_WORD[7:0]) - $past(ACC)) && CARRY == ($past(INSTR_WORD[7:0]) >= $past(ACC)))
    else $error("Literal subtract result or carry wrong.");
  file_sub_a: assert property (exec_done and $past(INSTR_WORD[13:8]) == FILE_SUB_OP |->
    ZERO == ($past(FILE_RDATA) == $past(ACC)) && FILE_WE == $past(INSTR_WORD[7])
    && DIGIT_CARRY == ($past(FILE_RDATA[3:0]) >= $past(ACC[3:0])))
    else $error("File subtract flags or routing wrong.");
endmodule : brse_core_sva

bind brse_core brse_core_sva brse_core_sva_i (.*);

/* test_bitop_return_subtract_exec.sv */
`timescale 1ns/1ps
module test_bitop_return_subtract_exec
  import brse_pkg::*;
;
  logic        clock, rst, fetch, pop, fwe, iwe, global_interrupt_enable, nop, cy, dc, zf;
  logic [13:0] word;
  logic [12:0] pc, stack_top;
  logic [7:0]  frd, fwd, icr, iwd, acc;
  logic [6:0]  fa;
  logic [7:0]  fregs [0:127];
  int          miscompares, check_count, cycles;

  brse_core brse_core_i (
    .CLOCK(clock), .RST(rst), .INSTR_WORD(word), .STACK_TOP_ENTRY(stack_top),
    .FILE_RDATA(frd), .INTERRUPT_CONTROL_REGISTER(icr), .PC(pc), .FETCH(fetch),
    .STACK_POP(pop), .FILE_ADDR(fa), .FILE_WDATA(fwd), .FILE_WE(fwe), .INTERRUPT_CONTROL_REGISTER_WE(iwe),
    .INTERRUPT_CONTROL_REGISTER_WDATA(iwd), .ACC(acc), .CARRY(cy), .DIGIT_CARRY(dc), .ZERO(zf),
    .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .NOP_CYCLE(nop));
  brse_prog_mem brse_prog_mem_i (.clock(clock), .rst(rst), .fetch(fetch), .pc(pc), .word(word));

  assign frd = fregs[fa];
  always @(posedge clock) begin
    if (fwe) begin
      fregs[fa] <= fwd;
    end
    if (iwe) begin
      icr <= iwd;
    end
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic put(input logic [6:0] a, input logic [13:0] w);
    brse_prog_mem_i.mem[a] = w;
  endtask : put

  // The previous program keeps running until reset, so the memory is cleared first.
  task automatic load();
    for (int i = 0; i < 128; i++) begin
      brse_prog_mem_i.mem[i] = NOP_CODE;
    end
  endtask : load

  task automatic start();
    @(posedge clock) rst <= 1'h1;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
  endtask : start

  // Sampling one nanosecond after the edge lets the registered outputs settle first.
  task automatic step(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clock);
        #1;
        k++;
      end while (fetch !== 1'h1 && k < 8);
    end
  endtask : step

  task automatic bit_ops();
    load();
    put(7'h00, 14'h17FF);
    put(7'h01, 14'h10FF);
    fregs[7'h7F] = 8'h0A;
    start();
    step(1);
    check({fwe, fa, fwd}, {1'h1, 7'h7F, 8'h8A});
    step(1);
    check({fwe, fa, fwd}, {1'h1, 7'h7F, 8'h88});
    check({cy, dc, zf}, 3'h0);
  endtask : bit_ops

  task automatic subtracts();
    load();
    put(7'h00, 14'h3D02);
    put(7'h01, 14'h0291);
    put(7'h02, 14'h0210);
    put(7'h03, 14'h3C01);
    fregs[7'h11] = 8'h01;
    fregs[7'h10] = 8'h03;
    start();
    step(1);
    check({acc, cy, dc, zf}, {8'h02, 3'h6});
    step(1);
    check({fwe, fa, fwd}, {1'h1, 7'h11, 8'hFF});
    check({acc, cy, dc, zf}, {8'h02, 3'h0});
    step(1);
    check({fwe, acc, cy, dc, zf}, {1'h0, 8'h01, 3'h6});
    step(1);
    check({acc, cy, dc, zf}, {8'h00, 3'h7});
  endtask : subtracts

  task automatic skips();
    load();
    put(7'h00, 14'h187F);
    put(7'h01, 14'h3C05);
    put(7'h02, 14'h1BFF);
    put(7'h03, 14'h3C05);
    fregs[7'h7F] = 8'h88;
    start();
    step(2);
    check({nop, acc}, {1'h1, 8'h00});
    check(pc, 13'h0002);
    step(2);
    check({nop, acc}, {1'h0, 8'h05});
  endtask : skips

  task automatic returns();
    load();
    put(7'h00, 14'h375A);
    put(7'h40, 14'h0009);
    put(7'h50, 14'h0008);
    icr = 8'h15;
    start();
    step(1);
    check({pop, acc, pc[6:0]}, {1'h1, 8'h5A, 7'h40});
    @(posedge clock) stack_top <= 13'h0050;
    step(1);
    check(nop, 1'h1);
    step(1);
    check({pop, iwe, iwd, global_interrupt_enable, pc}, {2'h3, 8'h95, 1'h1, 13'h0050});
    @(posedge clock) stack_top <= 13'h0060;
    step(2);
    check({pop, cy, dc, zf, global_interrupt_enable, pc}, {5'h11, 13'h0060});
  endtask : returns

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst = 1'h1;
    stack_top = 13'h0040;
    icr = 8'h00;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    bit_ops();
    subtracts();
    skips();
    returns();
    wrap_up();
  end
endmodule : test_bitop_return_subtract_exec
